// File: rtl/scc_top.v
// Sync, clamp and coast control of a graphics digitizer front end.
// Assumes all pins synchronous to clk_sys; one clk_sys cycle is one pixel period.
//
// Overview of operation
// - Blue offset is seven-bit offset binary in register bits 7 to 1, output on blue_offset.
// - Line polarity override 0 uses detected polarity; 1 uses programmed bit.
// - Input polarity 0 times from falling edge; 1 from rising edge.
// - Wrong programmed polarity keeps running but misplaces the internal clamp.
// - Output polarity bit sets hsync and green_sync outputs; 0 gives positive hsync, green_sync as received.
// - Line sync override 0 lets automatic status choose; 1 uses select bit.
// - Line select 0 is hsync, 1 green_sync; also when both active.
// - Frame sync output inverted when invert bit 0, passed when 1.
// - Frame sync override 0 lets automatic status choose; 1 uses select bit.
// - Frame select 0 routes vsync pin, 1 the sync separator output.
// - Clamp source 0 internal, placed from the selected line sync trailing edge; 1 external pin.
// - External clamp clamps all channels while its input is active.
// - Clamp polarity 1 clamps on low input; 0 clamps on high input.
// - Hold source 0 is hold_pll pin; 1 is the selected frame sync.
// - Hold polarity override 0 uses detected polarity; 1 programmed bit.
// - Hold polarity 1 holds while high; 0 holds while low.
// - Programmed hold polarity acts only while its override is set.
// - Seek bit 1 enters seek mode when no sync input is active.
// - Status reports activity on the selected line sync input.
// - Status shows green_sync or hsync feeding PLL; auto picks single active.
// - Status shows separator or vsync pin as frame sync source.
`timescale 1ns/10ps
`default_nettype none
`include "scc_defines.vh"

module scc_top
#(
    // Activity window in cycles; shorten for simulation
    parameter ACT_WIN_CYC = `SCC_ACT_WIN_NS / `SCC_CLK_NS
)
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Serial register port
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out_q,
    output wire       sda_oe,
    // Incoming sync and control pins
    input  wire       hsync_in,
    input  wire       green_sync_in,
    input  wire       vsync_in,
    input  wire       sep_vsync_in,
    input  wire       ext_clamp_in,
    input  wire       hold_pll_in,
    // Internal clamp timing settings
    input  wire [7:0] clamp_place,
    input  wire [7:0] clamp_len,
    // Datapath controls
    output reg        pll_line_sync_q,
    output reg        pll_lead_q,
    output reg        pll_hold_q,
    output reg        clamp_q,
    output reg        seek_q,
    output wire [6:0] blue_offset,
    // Sync outputs
    output reg        hsync_out_q,
    output reg        green_sync_out_q,
    output reg        vsync_out_q
);

    // ==========================================================
    // Register file
    reg  [7:0] blue_ofs_q;
    reg  [7:0] sync_ctl_q;
    reg  [7:0] input_ctl_q;

    wire [7:0] bus_addr;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire       wr_stb;
    wire [7:0] rd_data;

    scc_twi u_twi
    (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .scl       (scl),
        .sda_in    (sda_in),
        .sda_oe_q  (sda_oe),
        .addr_q    (bus_addr),
        .wr_addr_q (wr_addr),
        .wr_data_q (wr_data),
        .wr_stb_q  (wr_stb),
        .rd_data   (rd_data)
    );

    // Fields read out of the control registers
    wire hpol_ovr   = sync_ctl_q[`SCC_SC_HPOL_OVR];
    wire hpol_usr   = sync_ctl_q[`SCC_SC_HPOL];
    wire out_pol    = sync_ctl_q[`SCC_SC_OUT_POL];
    wire lsync_ovr  = sync_ctl_q[`SCC_SC_LSYNC_OVR];
    wire lsync_sel  = sync_ctl_q[`SCC_SC_LSYNC_SEL];
    wire vs_noinv   = sync_ctl_q[`SCC_SC_VS_NOINV];
    wire fsync_ovr  = sync_ctl_q[`SCC_SC_FSYNC_OVR];
    wire fsync_sel  = sync_ctl_q[`SCC_SC_FSYNC_SEL];
    wire clamp_ext  = input_ctl_q[`SCC_IC_CLAMP_EXT];
    wire clamp_pol  = input_ctl_q[`SCC_IC_CLAMP_POL];
    wire hold_sel   = input_ctl_q[`SCC_IC_HOLD_SEL];
    wire hold_ovr   = input_ctl_q[`SCC_IC_HOLD_OVR];
    wire hold_usr   = input_ctl_q[`SCC_IC_HOLD_POL];
    wire seek_en    = input_ctl_q[`SCC_IC_SEEK_EN];

    // Offset goes straight from its register bits to the converter
    assign blue_offset = blue_ofs_q[7:1];

    // Registers only change on the completed-byte strobe
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            blue_ofs_q  <= `SCC_RST_BLUE_OFS;
            sync_ctl_q  <= `SCC_RST_SYNC_CTL;
            input_ctl_q <= `SCC_RST_INPUT_CTL;
            sda_out_q   <= 1'b0;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                `SCC_ADR_BLUE_OFS:  blue_ofs_q  <= wr_data;
                `SCC_ADR_SYNC_CTL:  sync_ctl_q  <= wr_data;
                `SCC_ADR_INPUT_CTL: input_ctl_q <= wr_data;
                default:            sda_out_q   <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Activity detection: 0 hsync, 1 green_sync, 2 vsync
    wire [2:0] act_pin = {vsync_in, green_sync_in, hsync_in};
    wire [2:0] act;
    reg  [2:0] act_prev_q;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            act_prev_q <= 3'b000;
        else
            act_prev_q <= act_pin;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_act
            reg [16:0] idle_q;
            // A level held past the window counts as no signal
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    idle_q <= 17'h1ffff;
                else if (act_pin[gi] != act_prev_q[gi])
                    idle_q <= 17'h00000;
                else if (idle_q != 17'h1ffff)
                    idle_q <= idle_q + 17'h00001;
            end
            assign act[gi] = (idle_q < ACT_WIN_CYC[16:0]);
        end
    endgenerate

    // ==========================================================
    // Source selection
    reg als;
    reg afs;

    // Override forces the select bit; otherwise a single active source wins
    always @*
    begin
        if (lsync_ovr)
            als = lsync_sel;
        else if (act[0] && !act[1])
            als = 1'b0;
        else if (!act[0] && act[1])
            als = 1'b1;
        else
            als = lsync_sel;
    end

    // Frame source: vsync pin versus separator, judged by vsync and green_sync activity
    always @*
    begin
        if (fsync_ovr)
            afs = fsync_sel;
        else if (act[2] && !act[1])
            afs = 1'b0;
        else if (!act[2] && act[1])
            afs = 1'b1;
        else
            afs = fsync_sel;
    end

    wire line_raw  = als ? green_sync_in : hsync_in;
    wire frame_raw = afs ? sep_vsync_in : vsync_in;
    wire hold_raw  = hold_sel ? frame_raw : hold_pll_in;

    // ==========================================================
    // Polarity detection: 0 line sync, 1 hold; the shorter level is the pulse
    wire [1:0] pol_pin = {hold_raw, line_raw};
    wire [1:0] pol_det;

    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_pol
            reg        prev_q;
            reg [15:0] run_q;
            reg [15:0] hi_q;
            reg [15:0] lo_q;
            // Saturating run length; compare last high with last low
            always @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    prev_q <= 1'b0;
                    run_q  <= 16'h0000;
                    hi_q   <= 16'h0000;
                    lo_q   <= 16'hffff;
                end
                else
                begin
                    prev_q <= pol_pin[gi];
                    if (pol_pin[gi] != prev_q)
                    begin
                        run_q <= 16'h0000;
                        if (prev_q)
                            hi_q <= run_q;
                        else
                            lo_q <= run_q;
                    end
                    else if (run_q != 16'hffff)
                        run_q <= run_q + 16'h0001;
                end
            end
            assign pol_det[gi] = (hi_q < lo_q);
        end
    endgenerate

    // ==========================================================
    // Line sync normalised to active high for the PLL
    wire hpol     = hpol_ovr ? hpol_usr : pol_det[0];
    wire line_nrm = hpol ? line_raw : ~line_raw;
    wire lead     = line_nrm & ~pll_line_sync_q;
    // Trailing edge follows the assumed polarity, right or wrong
    wire trail    = ~line_nrm & pll_line_sync_q;

    // Hold polarity: programmed bit counts only under override
    wire hpol_hold = hold_ovr ? hold_usr : pol_det[1];
    wire hold_act  = hpol_hold ? hold_raw : ~hold_raw;

    // ==========================================================
    // Internal clamp timer, counted in pixel periods after trailing edge
    reg  [8:0] cl_cnt_q;
    reg        cl_run_q;
    wire [8:0] cl_start = {1'b0, clamp_place};
    wire [8:0] cl_end   = cl_start + {1'b0, clamp_len};
    wire       int_clamp = cl_run_q && (cl_cnt_q >= cl_start) && (cl_cnt_q < cl_end);
    // External pin, active level chosen by the polarity bit
    wire       ext_clamp = clamp_pol ? ~ext_clamp_in : ext_clamp_in;

    // A new trailing edge restarts the window, so a short line never stacks
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cl_cnt_q <= 9'h000;
            cl_run_q <= 1'b0;
        end
        else if (trail)
        begin
            cl_cnt_q <= 9'h001;
            cl_run_q <= 1'b1;
        end
        else if (cl_run_q)
        begin
            cl_cnt_q <= cl_cnt_q + 9'h001;
            if (cl_cnt_q >= cl_end)
                cl_run_q <= 1'b0;
        end
    end

    // ==========================================================
    // Registered datapath outputs
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pll_line_sync_q  <= 1'b0;
            pll_lead_q       <= 1'b0;
            pll_hold_q       <= 1'b0;
            clamp_q          <= 1'b0;
            seek_q           <= 1'b0;
            hsync_out_q      <= 1'b0;
            green_sync_out_q <= 1'b0;
            vsync_out_q      <= 1'b0;
        end
        else
        begin
            pll_line_sync_q  <= line_nrm;
            pll_lead_q       <= lead;
            pll_hold_q       <= hold_act;
            // One clamp flag drives all three channels
            clamp_q          <= clamp_ext ? ext_clamp : int_clamp;
            seek_q           <= seek_en & ~(|act);
            hsync_out_q      <= line_nrm ^ out_pol;
            green_sync_out_q <= green_sync_in ^ out_pol;
            vsync_out_q      <= vs_noinv ? frame_raw : ~frame_raw;
        end
    end

    // ==========================================================
    // Read-back
    function [7:0] scc_read;
        input [7:0] a;
        input [7:0] st;
        begin
            case (a)
                `SCC_ADR_BLUE_OFS:  scc_read = blue_ofs_q;
                `SCC_ADR_SYNC_CTL:  scc_read = sync_ctl_q;
                `SCC_ADR_INPUT_CTL: scc_read = input_ctl_q;
                `SCC_ADR_STATUS:    scc_read = st;
                default:            scc_read = 8'h00;
            endcase
        end
    endfunction

    reg [7:0] status;

    // Status bits live, sampled when the read byte is loaded
    always @*
    begin
        status = 8'h00;
        status[`SCC_ST_LINE_ACT]  = als ? act[1] : act[0];
        status[`SCC_ST_ALS]       = als;
        status[`SCC_ST_HPOL_DET]  = pol_det[0];
        status[`SCC_ST_FRAME_ACT] = act[2];
        status[`SCC_ST_AFS]       = afs;
        status[`SCC_ST_GREEN_ACT] = act[1];
    end

    assign rd_data = scc_read(bus_addr, status);

endmodule
`default_nettype wire

// File: rtl/scc_defines.vh
// Constants for the sync, clamp and coast control block.
// Assumes inclusion by bare name from the rtl files.
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

// ==========================================================
// Register offsets (8-bit sub-addresses)
`define SCC_ADR_BLUE_OFS   8'h0d
`define SCC_ADR_SYNC_CTL   8'h0e
`define SCC_ADR_INPUT_CTL  8'h0f
`define SCC_ADR_STATUS     8'h14

// ==========================================================
// Reset values
`define SCC_RST_BLUE_OFS   8'h7e
`define SCC_RST_SYNC_CTL   8'h40
`define SCC_RST_INPUT_CTL  8'h4e

// ==========================================================
// sync_control field positions
`define SCC_SC_HPOL_OVR    7
`define SCC_SC_HPOL        6
`define SCC_SC_OUT_POL     5
`define SCC_SC_LSYNC_OVR   4
`define SCC_SC_LSYNC_SEL   3
`define SCC_SC_VS_NOINV    2
`define SCC_SC_FSYNC_OVR   1
`define SCC_SC_FSYNC_SEL   0

// ==========================================================
// input_control field positions
`define SCC_IC_CLAMP_EXT   7
`define SCC_IC_CLAMP_POL   6
`define SCC_IC_HOLD_SEL    5
`define SCC_IC_HOLD_OVR    4
`define SCC_IC_HOLD_POL    3
`define SCC_IC_SEEK_EN     2

// ==========================================================
// status field positions
`define SCC_ST_LINE_ACT    7
`define SCC_ST_ALS         6
`define SCC_ST_HPOL_DET    5
`define SCC_ST_FRAME_ACT   4
`define SCC_ST_AFS         3
`define SCC_ST_GREEN_ACT   1

// ==========================================================
// Serial port and timing
`define SCC_DEV_ADDR       7'h4c
`define SCC_BYTE_BITS      4'h8
`define SCC_CLK_NS         10
`define SCC_ACT_WIN_NS     1000000

`endif

// File: rtl/scc_twi.v
// 2-wire serial register port slave: device address, sub-address,
// auto-incrementing data. Assumes scl and sda are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "scc_defines.vh"

module scc_twi
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // Serial pins
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_oe_q,
    // Register side
    output reg  [7:0] addr_q,
    output reg  [7:0] wr_addr_q,
    output reg  [7:0] wr_data_q,
    output reg        wr_stb_q,
    input  wire [7:0] rd_data
);

    // ==========================================================
    // States
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV  = 3'd1;
    localparam [2:0] ST_SUB  = 3'd2;
    localparam [2:0] ST_WDAT = 3'd3;
    localparam [2:0] ST_RDAT = 3'd4;

    reg  [2:0] st_q;
    reg  [3:0] cnt_q;
    reg        ack_q;
    reg  [7:0] sh_q;
    reg  [7:0] tx_q;
    reg        scl_q;
    reg        sda_q;

    // Bus events from previous samples
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start    = scl & scl_q & sda_q & ~sda_in;
    wire stop     = scl & scl_q & ~sda_q & sda_in;

    // ==========================================================
    // Protocol engine; write strobe fires at the data byte's ack
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q      <= ST_IDLE;
            cnt_q     <= 4'h0;
            ack_q     <= 1'b0;
            sh_q      <= 8'h00;
            tx_q      <= 8'h00;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            sda_oe_q  <= 1'b0;
            addr_q    <= 8'h00;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_stb_q  <= 1'b0;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            scl_q    <= scl;
            sda_q    <= sda_in;
            if (start)
            begin
                st_q     <= ST_DEV;
                cnt_q    <= 4'h0;
                ack_q    <= 1'b0;
                sda_oe_q <= 1'b0;
            end
            else if (stop)
            begin
                st_q     <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
            else if (st_q != ST_IDLE && scl_rise)
            begin
                if (ack_q)
                begin
                    // Master nack ends a read burst
                    if (st_q == ST_RDAT && sda_in)
                        st_q <= ST_IDLE;
                end
                else
                begin
                    sh_q  <= {sh_q[6:0], sda_in};
                    cnt_q <= cnt_q + 4'h1;
                end
            end
            else if (st_q != ST_IDLE && scl_fall)
            begin
                if (ack_q)
                begin
                    ack_q    <= 1'b0;
                    cnt_q    <= 4'h0;
                    sda_oe_q <= 1'b0;
                    if (st_q == ST_RDAT)
                    begin
                        tx_q     <= rd_data;
                        sda_oe_q <= ~rd_data[7];
                    end
                end
                else if (cnt_q == `SCC_BYTE_BITS)
                begin
                    ack_q <= 1'b1;
                    case (st_q)
                        ST_DEV:
                        begin
                            if (sh_q[7:1] == `SCC_DEV_ADDR)
                            begin
                                sda_oe_q <= 1'b1;
                                st_q     <= sh_q[0] ? ST_RDAT : ST_SUB;
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                        ST_SUB:
                        begin
                            addr_q   <= sh_q;
                            sda_oe_q <= 1'b1;
                            st_q     <= ST_WDAT;
                        end
                        ST_WDAT:
                        begin
                            wr_addr_q <= addr_q;
                            wr_data_q <= sh_q;
                            wr_stb_q  <= 1'b1;
                            addr_q    <= addr_q + 8'h01;
                            sda_oe_q  <= 1'b1;
                        end
                        ST_RDAT:
                        begin
                            sda_oe_q <= 1'b0;
                            addr_q   <= addr_q + 8'h01;
                        end
                        default:
                            st_q <= ST_IDLE;
                    endcase
                end
                else if (st_q == ST_RDAT)
                begin
                    tx_q     <= {tx_q[6:0], 1'b0};
                    sda_oe_q <= ~tx_q[6];
                end
            end
        end
    end

endmodule
`default_nettype wire

// File: verif/scc_sync_src.sv
// Video source model: line sync pulses on hsync or green_sync.
// Assumes the bench enables it and picks the line; idle lines sit low.
`timescale 1ns/10ps
`default_nettype none

module scc_sync_src
#(
    parameter int PER = 20,
    parameter int WID = 4
)
(
    // Clock
    input  wire logic clk_sys,
    // Controls
    input  wire logic en,
    input  wire logic sel,
    // Sync lines
    output var  logic hs,
    output var  logic gs
);
    int   cnt = 0;
    logic pulse;

    // Free-running line counter, moved just after the edge
    always @(posedge clk_sys)
        cnt <= #1 (cnt == PER - 1) ? 0 : cnt + 1;

    // Constant low when off, so no stray activity is seen
    always @*
    begin
        pulse = en && (cnt < WID);
        hs = pulse && !sel;
        gs = pulse && sel;
    end
endmodule

`default_nettype wire

// File: verif/scc_top_props.sv
// Concurrent checks on the scc_top ports.
// Assumes binding into scc_top with its activity window parameter.
`timescale 1ns/10ps
`default_nettype none

module scc_top_props
#(
    parameter ACT_WIN_CYC = 100000
)
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Serial port
    input wire logic       scl,
    input wire logic       sda_out_q,
    input wire logic       sda_oe,
    // Sync and datapath
    input wire logic       green_sync_in,
    input wire logic       green_sync_out_q,
    input wire logic       pll_line_sync_q,
    input wire logic       pll_lead_q,
    input wire logic       seek_q,
    input wire logic [6:0] blue_offset
);
    logic g_q;
    wire  g_rel;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Input copy, so output polarity shows as a plain relation
    always @(posedge clk_sys or posedge rst)
        if (rst)
            g_q <= 1'b0;
        else
            g_q <= green_sync_in;
    assign g_rel = green_sync_out_q ^ g_q;

    // ==========================================================
    // Sequences
    sequence ack_s;
        $rose(sda_oe);
    endsequence
    sequence boot_s;
        $fell(rst);
    endsequence

    // ==========================================================
    // Assertions
    sda_low_a: assert property (sda_out_q == 1'b0)
        else $error("sda data not held low");
    sda_move_a: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda moved while scl high");
    ack_end_a: assert property (ack_s |-> ##[1:200] !sda_oe)
        else $error("sda pull-down never released");
    lead_rise_a: assert property ($rose(pll_line_sync_q) |-> pll_lead_q)
        else $error("leading edge pulse missing");
    lead_only_a: assert property (pll_lead_q |-> pll_line_sync_q && !$past(pll_line_sync_q))
        else $error("leading edge pulse without a rise");
    boot_blue_a: assert property (boot_s |-> blue_offset == 7'h3f && !sda_oe)
        else $error("blue offset reset value wrong");
    blue_write_a: assert property ($changed(blue_offset) |-> $past(sda_oe))
        else $error("blue offset changed without a write");
    gpol_write_a: assert property ($changed(g_rel) |-> $past(sda_oe) || $past(sda_oe, 2))
        else $error("green sync polarity changed without a write");
    seek_boot_a: assert property (boot_s |-> ##[1:3] seek_q)
        else $error("seek mode not entered while idle");
endmodule

bind scc_top scc_top_props #(.ACT_WIN_CYC(ACT_WIN_CYC)) u_scc_top_props (
    .clk_sys(clk_sys), .rst(rst), .scl(scl), .sda_out_q(sda_out_q),
    .sda_oe(sda_oe), .green_sync_in(green_sync_in),
    .green_sync_out_q(green_sync_out_q), .pll_line_sync_q(pll_line_sync_q),
    .pll_lead_q(pll_lead_q), .seek_q(seek_q), .blue_offset(blue_offset));

`default_nettype wire

// File: verif/scc_top_tb.sv
// Self-checking bench for scc_top over its 2-wire register port.
// Assumes scc_top_props is bound and scc_sync_src supplies line sync.
`timescale 1ns/10ps
`default_nettype none
`include "scc_defines.vh"

module scc_top_tb;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       scl_m = 1'b1;
    logic       sda_m = 1'b1;
    logic       pen = 1'b0;
    logic       psel = 1'b0;
    logic [5:0] vin = 6'h00;
    logic [7:0] c_place = 8'h03;
    logic [7:0] c_len = 8'h05;
    logic [7:0] r;
    logic       ack;
    int         n_errors = 0;
    int         cmp_count = 0;
    int         n_cl;
    int         n_ld;
    wire        sda_oe, sda_w, p_hs, p_gs, hs_o;
    wire        line_s, lead, hold, clamp, seek, gs_o, vs_o;
    wire  [6:0] blue;
    // Mux cases: sync_control, input_control, pins, outputs, status
    logic [7:0] t_sc [4] = '{8'hd0, 8'hbb, 8'hd7, 8'hd6};
    logic [7:0] t_ic [4] = '{8'hd8, 8'h98, 8'hf0, 8'hb8};
    logic [5:0] t_in [4] = '{6'h24, 6'h13, 6'h03, 6'h28};
    logic [5:0] t_out [4] = '{6'h3a, 6'h2e, 6'h04, 6'h36};
    logic [7:0] t_st [4] = '{8'h00, 8'h48, 8'h08, 8'h00};
    logic [7:0] r_adr [4] = '{8'h0d, 8'h0e, 8'h0f, 8'h30};
    logic [7:0] r_val [4] = '{`SCC_RST_BLUE_OFS, `SCC_RST_SYNC_CTL, `SCC_RST_INPUT_CTL, 8'h00};

    // Open-drain line: released by master, pulled low by device
    assign sda_w = sda_m & ~sda_oe;

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // ==========================================================
    // Design and video source
    scc_top #(.ACT_WIN_CYC(64)) u_scc_top (
        .clk_sys(clk_sys), .rst(rst), .scl(scl_m), .sda_in(sda_w),
        .sda_out_q(), .sda_oe(sda_oe),
        .hsync_in(pen ? p_hs : vin[5]), .green_sync_in(pen ? p_gs : vin[4]),
        .vsync_in(vin[3]), .sep_vsync_in(vin[2]), .ext_clamp_in(vin[1]),
        .hold_pll_in(vin[0]), .clamp_place(c_place), .clamp_len(c_len),
        .pll_line_sync_q(line_s), .pll_lead_q(lead), .pll_hold_q(hold),
        .clamp_q(clamp), .seek_q(seek), .blue_offset(blue),
        .hsync_out_q(hs_o), .green_sync_out_q(gs_o), .vsync_out_q(vs_o));
    scc_sync_src u_scc_sync_src (.clk_sys(clk_sys), .en(pen), .sel(psel),
        .hs(p_hs), .gs(p_gs));

    // ==========================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One bit slot, sda moved only while scl is low
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_m = b;
        tick(2);
        scl_m = 1'b1;
        tick(2);
        s = sda_w;
        tick(2);
        scl_m = 1'b0;
    endtask
    // Start, also used as repeated start
    task automatic start;
        sda_m = 1'b1;
        tick(2);
        scl_m = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl_m = 1'b0;
    endtask
    task automatic stop;
        tick(2);
        sda_m = 1'b0;
        tick(2);
        scl_m = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask
    // Byte MSB first; ninth slot is released and sampled as acknowledge
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(1'b1, s);
        a = ~s;
    endtask
    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        start;
        xfer({`SCC_DEV_ADDR, 1'b0}, r, ack);
        xfer(sub, r, ack);
        xfer(d, r, ack);
        chk({7'h0, ack}, 8'h01);
        stop;
        tick(3);
    endtask
    // Read one byte; master ends with a not-acknowledge
    task automatic rd(input logic [7:0] sub, input logic [7:0] m, input logic [7:0] e);
        start;
        xfer({`SCC_DEV_ADDR, 1'b0}, r, ack);
        xfer(sub, r, ack);
        start;
        xfer({`SCC_DEV_ADDR, 1'b1}, r, ack);
        xfer(8'hff, r, ack);
        stop;
        chk(r & m, e);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        tick(2);
        rst = 1'b0;
        tick(4);
        chk({7'h0, seek}, 8'h01);
        for (int i = 0; i < 4; i++)
            rd(r_adr[i], 8'hff, r_val[i]);
        wr(`SCC_ADR_BLUE_OFS, 8'ha5);
        chk({1'b0, blue}, 8'h52);
        rd(`SCC_ADR_BLUE_OFS, 8'hff, 8'ha5);
        start;
        xfer(8'h5a, r, ack);
        stop;
        chk({7'h0, ack}, 8'h00);
        // Static pins through every override path
        for (int i = 0; i < 4; i++)
        begin
            wr(`SCC_ADR_SYNC_CTL, t_sc[i]);
            wr(`SCC_ADR_INPUT_CTL, t_ic[i]);
            vin = t_in[i];
            tick(4);
            chk({hs_o, line_s, clamp, hold, vs_o, gs_o}, t_out[i]);
            rd(`SCC_ADR_STATUS, 8'h48, t_st[i]);
        end
        // Live line sync with right and wrong programmed polarity
        vin = 6'h00;
        wr(`SCC_ADR_INPUT_CTL, 8'h44);
        pen = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wr(`SCC_ADR_SYNC_CTL, i ? 8'h90 : 8'hd0);
            tick(60);
            n_cl = 0;
            n_ld = 0;
            repeat (200)
            begin
                tick(1);
                n_cl += (clamp === 1'b1);
                n_ld += (lead === 1'b1);
            end
            chk(n_cl[7:0], 8'd50);
            chk(n_ld[7:0], 8'd10);
            chk({7'h0, seek}, 8'h00);
            rd(`SCC_ADR_STATUS, 8'hc0, 8'h80);
        end
        // Only green_sync active under automatic choice
        psel = 1'b1;
        wr(`SCC_ADR_SYNC_CTL, 8'h40);
        tick(150);
        rd(`SCC_ADR_STATUS, 8'h62, 8'h62);
        final_report;
    end

    // Guard against a hung sequence
    initial
    begin
        #1000000;
        n_errors++;
        final_report;
    end
endmodule

`default_nettype wire
